//--- include/spdif_in_pkg.sv
// Constants shared by the S/PDIF transmitter serial input stage.
// Assumes a single 100 MHz core clock and pin inputs synchronised in the stage.
package spdif_in_pkg;

  // ****************************************************************
  // Serial format and word width selects
  // ****************************************************************
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_RJ  = 2'h2;

  localparam logic [1:0] WID_16 = 2'h0;
  localparam logic [1:0] WID_18 = 2'h1;
  localparam logic [1:0] WID_20 = 2'h2;
  localparam logic [1:0] WID_24 = 2'h3;

  localparam int WORD_MAX = 24;

  // ****************************************************************
  // Frame sync to MSB delays in serial clocks
  // ****************************************************************
  localparam logic [5:0] DLY_I2S   = 6'h01;
  localparam logic [5:0] DLY_LJ    = 6'h00;
  localparam logic [5:0] DLY_RJ_16 = 6'h10;
  localparam logic [5:0] DLY_RJ_18 = 6'h0e;
  localparam logic [5:0] DLY_RJ_20 = 6'h0c;
  localparam logic [5:0] DLY_RJ_24 = 6'h08;
  localparam logic [5:0] CNT_SAT   = 6'h3f;

  // ****************************************************************
  // Pin sync vector layout and oversampling divider
  // ****************************************************************
  localparam int PIN_DATA = 0;
  localparam int PIN_FS   = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_OSC  = 3;
  localparam int PIN_N    = 4;

  localparam logic [1:0] DIV_LAST_256 = 2'h1;
  localparam logic [1:0] DIV_LAST_384 = 2'h2;
  localparam logic [3:0] OSC_TIMEOUT  = 4'hf;

  typedef enum logic [1:0] {
    RDY_EMPTY = 2'b01,
    RDY_FULL  = 2'b10
  } ready_state_e;

endpackage

//--- rtl/biphase_clk_div.sv
// Divider from the oversampling clock down to the internal biphase clock tick.
// Assumes osc_rise is a one-cycle pulse per synchronised oversampling edge.
`timescale 1ns/1ps
module biphase_clk_div (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Oversampling edge and ratio
  input  wire logic osc_rise,
  input  wire logic ratio_384,
  // Biphase tick and clock presence
  output logic      tick_q,
  output logic      present_q
);

  logic [1:0] div_q;
  logic [3:0] idle_q;
  logic [1:0] last;

  // Divide by 3 for 384 x FS, by 2 for 256 x FS: both give 128 x FS.
  assign last = ratio_384 ? spdif_in_pkg::DIV_LAST_384 : spdif_in_pkg::DIV_LAST_256;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (osc_rise) begin
        if (div_q >= last) begin
          div_q  <= 2'h0;
          tick_q <= present_q;
        end else begin
          div_q <= div_q + 2'h1;
        end
      end
    end
  end

  // A missing oversampling clock stops the transmitter.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q    <= 4'h0;
      present_q <= 1'b0;
    end else if (osc_rise) begin
      idle_q    <= 4'h0;
      present_q <= 1'b1;
    end else if (idle_q == spdif_in_pkg::OSC_TIMEOUT) begin
      present_q <= 1'b0;
    end else begin
      idle_q <= idle_q + 4'h1;
    end
  end

  a_tick_single : assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick_q |=> !tick_q) else $error("biphase tick longer than one cycle");
  a_tick_needs_osc : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !present_q |=> !tick_q) else $error("tick without oversampling clock");

endmodule

//--- rtl/spdif_serial_in.sv
// Serial audio input stage of an S/PDIF transmitter.
// Assumes serial clock, frame sync, data and oversampling clock arrive from pins.
`timescale 1ns/1ps
module spdif_serial_in (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Serial audio pins
  input  wire logic        serial_clk,
  input  wire logic        frame_sync,
  input  wire logic        serial_data,
  input  wire logic        oversample_clock_in,
  // Configuration
  input  wire logic [1:0]  fmt_sel,
  input  wire logic [1:0]  width_sel,
  input  wire logic        ratio_384,
  // Encoder side
  input  wire logic        frame_take,
  output logic      [23:0] left_word_q,
  output logic      [23:0] right_word_q,
  output logic             frame_ready_q,
  output logic             biphase_tick_q,
  output logic             osc_present_q
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [5:0] width_of(input logic [1:0] w);
    case (w)
      spdif_in_pkg::WID_16: width_of = 6'h10;
      spdif_in_pkg::WID_18: width_of = 6'h12;
      spdif_in_pkg::WID_20: width_of = 6'h14;
      default:              width_of = 6'h18;
    endcase
  endfunction

  function automatic logic [5:0] delay_of(input logic [1:0] f, input logic [1:0] w);
    if (f == spdif_in_pkg::FMT_LJ) begin
      delay_of = spdif_in_pkg::DLY_LJ;
    end else if (f == spdif_in_pkg::FMT_RJ) begin
      case (w)
        spdif_in_pkg::WID_16: delay_of = spdif_in_pkg::DLY_RJ_16;
        spdif_in_pkg::WID_18: delay_of = spdif_in_pkg::DLY_RJ_18;
        spdif_in_pkg::WID_20: delay_of = spdif_in_pkg::DLY_RJ_20;
        default:              delay_of = spdif_in_pkg::DLY_RJ_24;
      endcase
    end else begin
      delay_of = spdif_in_pkg::DLY_I2S;
    end
  endfunction

  // Unused select code 3 falls back to the I2S default.
  function automatic logic left_of(input logic [1:0] f, input logic fs);
    left_of = (f == spdif_in_pkg::FMT_LJ || f == spdif_in_pkg::FMT_RJ) ? fs : !fs;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [spdif_in_pkg::PIN_N-1:0] sync1_q;
  logic [spdif_in_pkg::PIN_N-1:0] sync2_q;
  logic                           sclk_last_q;
  logic                           osc_last_q;
  logic                           sclk_rise;
  logic                           osc_rise;
  logic                           fs_s;
  logic                           data_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      sclk_last_q <= 1'b0;
      osc_last_q  <= 1'b0;
    end else begin
      sync1_q     <= {oversample_clock_in, serial_clk, frame_sync, serial_data};
      sync2_q     <= sync1_q;
      sclk_last_q <= sync2_q[spdif_in_pkg::PIN_SCLK];
      osc_last_q  <= sync2_q[spdif_in_pkg::PIN_OSC];
    end
  end

  assign sclk_rise = sync2_q[spdif_in_pkg::PIN_SCLK] && !sclk_last_q;
  assign osc_rise  = sync2_q[spdif_in_pkg::PIN_OSC] && !osc_last_q;
  assign fs_s      = sync2_q[spdif_in_pkg::PIN_FS];
  assign data_s    = sync2_q[spdif_in_pkg::PIN_DATA];

  // ****************************************************************
  // Oversampling divider
  // ****************************************************************
  biphase_clk_div u_div (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .osc_rise  (osc_rise),
    .ratio_384 (ratio_384),
    .tick_q    (biphase_tick_q),
    .present_q (osc_present_q)
  );

  // ****************************************************************
  // Bit position and word capture
  // ****************************************************************
  logic        fs_last_q;
  logic [5:0]  bit_cnt_q;
  logic        chan_left_q;
  logic [23:0] shift_q;
  logic        fs_changed;
  logic [5:0]  cnt_now;
  logic        left_now;
  logic [5:0]  dly;
  logic [5:0]  wid;
  logic        in_word;
  logic        last_bit;
  logic [23:0] shift_d;
  logic [23:0] aligned;
  logic        store;
  logic        store_right;

  assign dly        = delay_of(fmt_sel, width_sel);
  assign wid        = width_of(width_sel);
  assign fs_changed = fs_s != fs_last_q;
  assign cnt_now    = fs_changed ? 6'h00 : bit_cnt_q;
  assign left_now   = fs_changed ? left_of(fmt_sel, fs_s) : chan_left_q;
  assign in_word    = (cnt_now >= dly) && (cnt_now < dly + wid);
  assign last_bit   = cnt_now == dly + wid - 6'h01;
  assign shift_d    = {shift_q[22:0], data_s};
  // Words leave MSB-aligned in 24 bits with zero padding below narrower widths.
  assign aligned    = shift_d << (6'(spdif_in_pkg::WORD_MAX) - wid);
  assign store      = sclk_rise && in_word && last_bit && osc_present_q;
  assign store_right = store && !left_now;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_last_q   <= 1'b0;
      bit_cnt_q   <= spdif_in_pkg::CNT_SAT;
      chan_left_q <= 1'b0;
    end else if (sclk_rise) begin
      fs_last_q   <= fs_s;
      chan_left_q <= left_now;
      bit_cnt_q   <= (cnt_now == spdif_in_pkg::CNT_SAT) ? cnt_now : cnt_now + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 24'h000000;
    end else if (sclk_rise && in_word) begin
      shift_q <= shift_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_word_q  <= 24'h000000;
      right_word_q <= 24'h000000;
    end else if (store) begin
      if (left_now) begin
        left_word_q <= aligned;
      end else begin
        right_word_q <= aligned;
      end
    end
  end

  // ****************************************************************
  // Frame hand-off to the encoder
  // ****************************************************************
  spdif_in_pkg::ready_state_e rdy_q;

  // The ready flag is kept as its own register so that the output leaves a flip-flop.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_q         <= spdif_in_pkg::RDY_EMPTY;
      frame_ready_q <= 1'b0;
    end else begin
      case (rdy_q)
        spdif_in_pkg::RDY_EMPTY: begin
          if (store_right) begin
            rdy_q         <= spdif_in_pkg::RDY_FULL;
            frame_ready_q <= 1'b1;
          end
        end
        spdif_in_pkg::RDY_FULL: begin
          if (frame_take && !store_right) begin
            rdy_q         <= spdif_in_pkg::RDY_EMPTY;
            frame_ready_q <= 1'b0;
          end
        end
        default: begin
          rdy_q         <= spdif_in_pkg::RDY_EMPTY;
          frame_ready_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_lj_no_delay : assert property (
    sclk_rise && fs_changed && fmt_sel == spdif_in_pkg::FMT_LJ |-> in_word && left_now == fs_s)
    else $error("left justified MSB not at sync transition");
  a_i2s_one_late : assert property (
    sclk_rise && fs_changed && fmt_sel == spdif_in_pkg::FMT_I2S |-> !in_word ##1 bit_cnt_q == 6'h01)
    else $error("I2S MSB not one clock late");
  a_i2s_left_low : assert property (
    sclk_rise && fs_changed && fmt_sel == spdif_in_pkg::FMT_I2S && !fs_s |=> chan_left_q)
    else $error("I2S low sync not left");
  a_rj_left_high : assert property (
    sclk_rise && fs_changed && fmt_sel == spdif_in_pkg::FMT_RJ && fs_s |=> chan_left_q)
    else $error("right justified high sync not left");
  a_rj_24_start : assert property (
    sclk_rise && fmt_sel == spdif_in_pkg::FMT_RJ && width_sel == spdif_in_pkg::WID_24 |->
    in_word == (cnt_now >= spdif_in_pkg::DLY_RJ_24 && cnt_now < 6'h20))
    else $error("right justified 24 bit MSB delay wrong");
  a_sample_edge : assert property (
    !sclk_rise |=> $stable(shift_q) && $stable(bit_cnt_q))
    else $error("sampling away from serial clock rise");
  a_width_pad : assert property (
    store && left_now && width_sel == spdif_in_pkg::WID_16 |=> left_word_q[7:0] == 8'h00)
    else $error("16 bit word not padded");
  a_frame_hold : assert property (
    frame_ready_q && !frame_take && !store |=> frame_ready_q && $stable(left_word_q) && $stable(right_word_q))
    else $error("frame words not held");
  a_no_osc_stop : assert property (
    !osc_present_q |=> $stable(left_word_q) && $stable(right_word_q))
    else $error("capture without oversampling clock");
  a_fmt_select : assert property (
    sclk_rise && fs_changed && fmt_sel == spdif_in_pkg::FMT_RJ |-> !in_word)
    else $error("right justified word started at transition");

  c_frame_i2s : cover property (store_right && fmt_sel == spdif_in_pkg::FMT_I2S);
  c_frame_lj  : cover property (store_right && fmt_sel == spdif_in_pkg::FMT_LJ);
  c_frame_rj  : cover property (store_right && fmt_sel == spdif_in_pkg::FMT_RJ);
  c_take      : cover property (frame_ready_q && frame_take);

endmodule

//--- bench/audio_source.sv
// Model of the external audio source: serial clock, frame sync, data and oversampling clock.
// Assumes a 100 MHz ref_clk; every pin changes on its falling edge.
`timescale 1ns/1ps
module audio_source (
  // Clock and oversampling enable
  input  wire logic ref_clk,
  input  wire logic osc_en,
  // Serial audio pins
  output logic      serial_clk,
  output logic      frame_sync,
  output logic      serial_data,
  output logic      oversample_clock_in
);
  logic [1:0] osc_div = 2'h0;
  initial begin
    serial_clk = 1'b0;
    frame_sync = 1'b0;
    serial_data = 1'b0;
    oversample_clock_in = 1'b0;
  end
  // Oversampling clock at 25 MHz; it stands low while disabled.
  always @(negedge ref_clk) begin
    osc_div <= osc_div + 2'h1;
    oversample_clock_in <= osc_en & osc_div[1];
  end
  // One serial clock period of 100 ns; sync and data settle half a period before the rise.
  task automatic drive_bit(input logic fs, input logic d);
    frame_sync = fs;
    serial_data = d;
    repeat (5) @(negedge ref_clk);
    serial_clk = 1'b1;
    repeat (5) @(negedge ref_clk);
    serial_clk = 1'b0;
  endtask
  task automatic send_frame(input logic [1:0] fmt, input logic [1:0] wsel, input logic [23:0] lw,
                            input logic [23:0] rw);
    int         nb;
    int         dly;
    logic       lhi;
    logic       b;
    logic [23:0] w;
    nb = (wsel == spdif_in_pkg::WID_24) ? 24 : 16 + 2 * int'(wsel);
    lhi = (fmt == spdif_in_pkg::FMT_LJ) || (fmt == spdif_in_pkg::FMT_RJ);
    dly = (fmt == spdif_in_pkg::FMT_LJ) ? 0 : (fmt == spdif_in_pkg::FMT_RJ) ? 32 - nb : 1;
    b = ~serial_data;
    drive_bit(~lhi, b);
    for (int h = 0; h < 2; h++) begin
      w = (h == 0) ? lw : rw;
      for (int n = 0; n < 32; n++) begin
        if (n >= dly && n < dly + nb) begin
          b = w[nb - 1 - (n - dly)];
        end else begin
          b = ~b;
        end
        drive_bit((h == 0) ? lhi : ~lhi, b);
      end
    end
    serial_data = ~b;
  endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the serial input stage of the S/PDIF transmitter.
// Assumes the audio_source model drives all serial and oversampling pins.
`timescale 1ns/1ps
module testbench;
  logic        ref_clk;
  logic        rst_n;
  logic        osc_en;
  logic        ratio_384;
  logic        frame_take;
  logic [1:0]  fmt_sel;
  logic [1:0]  width_sel;
  logic        serial_clk;
  logic        frame_sync;
  logic        serial_data;
  logic        oversample_clock_in;
  logic [23:0] left_word_q;
  logic [23:0] right_word_q;
  logic        frame_ready_q;
  logic        biphase_tick_q;
  logic        osc_present_q;
  logic [23:0] lw;
  logic [23:0] rw;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          ticks = 0;
  audio_source src_u (.ref_clk(ref_clk), .osc_en(osc_en), .serial_clk(serial_clk), .frame_sync(frame_sync),
                      .serial_data(serial_data), .oversample_clock_in(oversample_clock_in));
  spdif_serial_in dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(serial_clk), .frame_sync(frame_sync),
                         .serial_data(serial_data), .oversample_clock_in(oversample_clock_in),
                         .fmt_sel(fmt_sel), .width_sel(width_sel), .ratio_384(ratio_384),
                         .frame_take(frame_take), .left_word_q(left_word_q), .right_word_q(right_word_q),
                         .frame_ready_q(frame_ready_q), .biphase_tick_q(biphase_tick_q),
                         .osc_present_q(osc_present_q));
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  // Tick counter and hang guard; the full run needs about 12000 cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (biphase_tick_q === 1'b1) ticks++;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected word: MSB-aligned in 24 bits, low bits zero.
  function automatic logic [23:0] exp_word(input logic [1:0] ws, input logic [23:0] w);
    return w << ((ws == spdif_in_pkg::WID_24) ? 0 : 8 - 2 * int'(ws));
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    osc_en = 1'b1;
    ratio_384 = 1'b1;
    frame_take = 1'b0;
    fmt_sel = spdif_in_pkg::FMT_I2S;
    width_sel = spdif_in_pkg::WID_16;
    void'($urandom(32'h3a1b));
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    check("reset left", 24'h000000, left_word_q);
    check("reset ready", 24'h000000, {23'h0, frame_ready_q});
    repeat (20) @(negedge ref_clk);
    check("osc present", 24'h000001, {23'h0, osc_present_q});
    $display("test reset done");
    // ****************************************************************
    // Biphase tick rate for both oversampling ratios
    // ****************************************************************
    for (int k = 0; k < 2; k++) begin
      ratio_384 = (k == 0);
      repeat (30) @(negedge ref_clk);
      @(posedge biphase_tick_q);
      // The tick just seen is counted at the next rising edge; clear after it.
      repeat (2) @(negedge ref_clk);
      ticks = 0;
      repeat (234) @(negedge ref_clk);
      check("tick count", 24'(234 / ((k == 0) ? 12 : 8)), 24'(ticks));
    end
    $display("test biphase done");
    // ****************************************************************
    // Every format and width, with a hand-take after each frame
    // ****************************************************************
    for (int f = 0; f < 4; f++) begin
      for (int ws = 0; ws < 4; ws++) begin
        lw = (f == 0 && ws == 0) ? 24'hffffff : 24'($urandom);
        rw = (f == 0 && ws == 0) ? 24'h000000 : 24'($urandom);
        fmt_sel = 2'(f);
        width_sel = 2'(ws);
        src_u.send_frame(2'(f), 2'(ws), lw, rw);
        repeat (10) @(negedge ref_clk);
        check("left word", exp_word(2'(ws), lw), left_word_q);
        check("right word", exp_word(2'(ws), rw), right_word_q);
        check("ready set", 24'h000001, {23'h0, frame_ready_q});
        frame_take = 1'b1;
        @(negedge ref_clk);
        frame_take = 1'b0;
        check("ready cleared", 24'h000000, {23'h0, frame_ready_q});
        check("left held", exp_word(2'(ws), lw), left_word_q);
        $display("test format %0d width %0d done", f, ws);
      end
    end
    // ****************************************************************
    // Oversampling clock absent: nothing stored, no ticks
    // ****************************************************************
    osc_en = 1'b0;
    repeat (30) @(negedge ref_clk);
    check("osc absent", 24'h000000, {23'h0, osc_present_q});
    ticks = 0;
    src_u.send_frame(spdif_in_pkg::FMT_LJ, spdif_in_pkg::WID_24, 24'h5a5a5a, 24'ha5a5a5);
    repeat (10) @(negedge ref_clk);
    check("no ticks", 24'h000000, 24'(ticks));
    check("left kept", exp_word(2'h3, lw), left_word_q);
    check("no ready", 24'h000000, {23'h0, frame_ready_q});
    $display("test osc absent done");
    tally_and_finish();
  end
endmodule
